// ==== logic/dgoc_consts.svh ====
// Constants of the global DMA operation control block: offsets, fields, codes.
// Assumes one 10 MHz clock and a simple strobe register port.
// Contract
// RL1 - Mode 00 (reset): fixed order channel 0, 3, 2, 1.
// RL2 - Mode 01: fixed order channel 1, 3, 2, 0.
// RL3 - Mode 10: round-robin, starting as channel 0, 3, 2, 1 after reset.
// RL4 - Mode 11: external-pin-alternating, starting as channel 3, 2, 1, 0.
// RL5 - Address error by a DMA transfer sets flag bit 2; resets to zero.
// RL6 - Address error flag clears only by writing zero after reading it as one.
// RL7 - Non-maskable interrupt sets flag bit 1; cleared by read-one then write-zero.
// RL8 - Writing one to either flag leaves it unchanged; zero only clears.
// RL9 - Master enable bit 0, reset zero, gates transfers on all channels.
// RL10 - Channels 0/1 share level field 15..12, channels 2/3 field 11..8.
// RL11 - Either flag set suspends all channels until software clears it.
// RL12 - Round-robin: finishing channel drops to lowest, others move up.
`ifndef DGOC_CONSTS_SVH
`define DGOC_CONSTS_SVH

`define DGOC_ADDR_W      8
`define DGOC_DATA_W      16
`define DGOC_OFF_OPCTL   8'h00
`define DGOC_OFF_INTERRUPT_PRIORITY_BANK_C    8'h04
`define DGOC_OFF_STAT    8'h08
`define DGOC_OFF_MASK    8'h0c

`define DGOC_BIT_PRI_HI  9
`define DGOC_BIT_PRI_LO  8
`define DGOC_BIT_AE      2
`define DGOC_BIT_NONMASKABLE_INT_FLAG    1
`define DGOC_BIT_DME     0
`define DGOC_IPL01_MSB   15
`define DGOC_IPL01_LSB   12
`define DGOC_IPL23_MSB   11
`define DGOC_IPL23_LSB   8

`define DGOC_EV_AE       0
`define DGOC_EV_NMI      1
`define DGOC_EV_W        2

`define DGOC_MODE_FIX0   2'h0
`define DGOC_MODE_FIX1   2'h1
`define DGOC_MODE_RR     2'h2
`define DGOC_MODE_ALT    2'h3

// Orders, slot 0 (lowest bits) highest priority
`define DGOC_ORD_FIX0    8'h6c
`define DGOC_ORD_FIX1    8'h2d
`define DGOC_ORD_ALT_A   8'h1b
`define DGOC_ORD_ALT_B   8'h4e

`define DGOC_RST_OPCTL   16'h0000
`define DGOC_RST_INTERRUPT_PRIORITY_BANK_C    16'h0000

`endif

// ==== logic/dgoc_pkg.sv ====
// Types of the global DMA operation control block.
// Assumes the constants header is included by users alongside.
package dgoc_pkg;
	timeunit 1ns;
	timeprecision 1ns;
	typedef logic [1:0]       dgoc_chan_t;
	typedef dgoc_chan_t [3:0] dgoc_order_t;

	// Software-visible operation control fields
	typedef struct packed {
		logic [1:0] priority_mode;
		logic       address_error_flag;
		logic       nonmaskable_int_flag;
		logic       master_transfer_enable;
	} dgoc_opctl_s;

	// One register port access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} dgoc_bus_s;
endpackage : dgoc_pkg

// ==== logic/dgoc_top.sv ====
// Global DMA operation control: priority arbitration, master enable, error flags.
// Assumes all inputs synchronous to clock_i; event inputs are one-cycle pulses.
`include "dgoc_consts.svh"

module dgoc_top #(
	parameter int NCH = 4
) (
	input  wire logic                     clock_i,
	input  wire logic                     reset_n_i,
	input  wire logic [`DGOC_ADDR_W-1:0]  addr_i,
	input  wire logic [`DGOC_DATA_W-1:0]  wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [`DGOC_DATA_W-1:0]  rdata_o,
	input  wire logic [NCH-1:0]           req_i,
	input  wire logic [NCH-1:0]           done_i,
	input  wire logic                     addr_err_i,
	input  wire logic                     nmi_i,
	output logic      [NCH-1:0]           grant_o,
	output logic                          run_o,
	output logic      [3:0]               ipl_ch01_o,
	output logic      [3:0]               ipl_ch23_o,
	output logic                          irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic                 rst_meta_n;
	logic                 rst_n;
	dgoc_pkg::dgoc_bus_s  bus;
	dgoc_pkg::dgoc_opctl_s opctl;
	dgoc_pkg::dgoc_order_t order;
	logic [15:0]          interrupt_priority_bank_c;
	logic                 ae_armed;
	logic                 nmi_armed;
	logic [`DGOC_EV_W-1:0] irq_stat;
	logic [`DGOC_EV_W-1:0] irq_mask;
	logic                 alt_phase;
	logic                 running;
	logic                 wr_opctl;
	logic                 rd_opctl;
	logic                 rd_stat;
	logic [NCH-1:0]       next_grant;
	logic [1:0]           done_ch;
	logic                 any_done;
	logic [15:0]          opctl_word;

	// Moves the given channel to the lowest slot, the channels behind it shift up one slot
	function automatic dgoc_pkg::dgoc_order_t dgoc_demote(input dgoc_pkg::dgoc_order_t o,
		input dgoc_pkg::dgoc_chan_t ch);
		dgoc_pkg::dgoc_order_t r;
		int                    k;
		r = o;
		k = 0;
		for (int i = 0; i < 4; i++) begin
			if (o[i] != ch) begin
				r[k] = o[i];
				k = k + 1;
			end
		end
		r[3] = ch;
		return r;
	endfunction : dgoc_demote

	// Starting order of a priority mode
	function automatic dgoc_pkg::dgoc_order_t dgoc_start(input logic [1:0] mode);
		dgoc_pkg::dgoc_order_t r;
		unique case (mode)
			`DGOC_MODE_FIX0: r = `DGOC_ORD_FIX0;
			`DGOC_MODE_FIX1: r = `DGOC_ORD_FIX1;
			`DGOC_MODE_RR:   r = `DGOC_ORD_FIX0;
			`DGOC_MODE_ALT:  r = `DGOC_ORD_ALT_A;
		endcase
		return r;
	endfunction : dgoc_start

	// Reset release through two flip-flops
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// Bundle the register port and decode it
	assign bus        = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
	assign wr_opctl   = bus.wr && (bus.addr == `DGOC_OFF_OPCTL);
	assign rd_opctl   = bus.rd && (bus.addr == `DGOC_OFF_OPCTL);
	assign rd_stat    = bus.rd && (bus.addr == `DGOC_OFF_STAT);
	assign running    = opctl.master_transfer_enable && !opctl.address_error_flag
		&& !opctl.nonmaskable_int_flag; // RL9 RL11

	// Register image of the operation control word
	always_comb begin
		opctl_word                         = 16'h0000;
		opctl_word[`DGOC_BIT_PRI_HI]       = opctl.priority_mode[1];
		opctl_word[`DGOC_BIT_PRI_LO]       = opctl.priority_mode[0];
		opctl_word[`DGOC_BIT_AE]           = opctl.address_error_flag;
		opctl_word[`DGOC_BIT_NONMASKABLE_INT_FLAG]         = opctl.nonmaskable_int_flag;
		opctl_word[`DGOC_BIT_DME]          = opctl.master_transfer_enable;
	end

	// Mode and master enable, written directly
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			opctl.priority_mode          <= `DGOC_MODE_FIX0; // RL1
			opctl.master_transfer_enable <= 1'b0; // RL9
		end else if (wr_opctl) begin
			opctl.priority_mode          <= {bus.wdata[`DGOC_BIT_PRI_HI], bus.wdata[`DGOC_BIT_PRI_LO]};
			opctl.master_transfer_enable <= bus.wdata[`DGOC_BIT_DME]; // RL9
		end
	end

	// Flags arm on a read showing one; disarm on any write of the register
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ae_armed  <= 1'b0;
			nmi_armed <= 1'b0;
		end else if (wr_opctl) begin
			ae_armed  <= 1'b0;
			nmi_armed <= 1'b0;
		end else if (rd_opctl) begin
			ae_armed  <= opctl.address_error_flag; // RL6
			nmi_armed <= opctl.nonmaskable_int_flag; // RL7
		end
	end

	// Address error flag: set wins over clear
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			opctl.address_error_flag <= 1'b0; // RL5
		end else if (addr_err_i) begin
			opctl.address_error_flag <= 1'b1; // RL5
		end else if (wr_opctl && ae_armed && !bus.wdata[`DGOC_BIT_AE]) begin
			opctl.address_error_flag <= 1'b0; // RL6 RL8
		end
	end

	// Non-maskable interrupt flag: set wins over clear
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			opctl.nonmaskable_int_flag <= 1'b0;
		end else if (nmi_i) begin
			opctl.nonmaskable_int_flag <= 1'b1; // RL7
		end else if (wr_opctl && nmi_armed && !bus.wdata[`DGOC_BIT_NONMASKABLE_INT_FLAG]) begin
			opctl.nonmaskable_int_flag <= 1'b0; // RL7 RL8
		end
	end

	// Interrupt priority bank with the two channel-pair level fields
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_priority_bank_c <= `DGOC_RST_INTERRUPT_PRIORITY_BANK_C;
		end else if (bus.wr && (bus.addr == `DGOC_OFF_INTERRUPT_PRIORITY_BANK_C)) begin
			interrupt_priority_bank_c <= bus.wdata; // RL10
		end
	end

	// Event status, sticky, cleared by its read; set wins
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= '0;
		end else begin
			irq_stat[`DGOC_EV_AE]  <= addr_err_i || (irq_stat[`DGOC_EV_AE] && !rd_stat);
			irq_stat[`DGOC_EV_NMI] <= nmi_i || (irq_stat[`DGOC_EV_NMI] && !rd_stat);
		end
	end

	// Interrupt mask
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= '0;
		end else if (bus.wr && (bus.addr == `DGOC_OFF_MASK)) begin
			irq_mask <= bus.wdata[`DGOC_EV_W-1:0];
		end
	end

	// Lowest completing channel
	always_comb begin
		done_ch  = 2'h0;
		any_done = |done_i;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (done_i[i]) begin
				done_ch = 2'(i);
			end
		end
	end

	// Priority order: reloads on a mode write, rotates in the dynamic modes
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			order     <= `DGOC_ORD_FIX0; // RL1 RL3
			alt_phase <= 1'b0;
		end else if (wr_opctl) begin
			order     <= dgoc_start({bus.wdata[`DGOC_BIT_PRI_HI], bus.wdata[`DGOC_BIT_PRI_LO]}); // RL2 RL3 RL4
			alt_phase <= 1'b0;
		end else if (any_done && (opctl.priority_mode == `DGOC_MODE_RR)) begin
			order     <= dgoc_demote(order, done_ch); // RL12
		end else if (any_done && (opctl.priority_mode == `DGOC_MODE_ALT)) begin
			order     <= alt_phase ? `DGOC_ORD_ALT_A : `DGOC_ORD_ALT_B; // RL4
			alt_phase <= !alt_phase;
		end
	end

	// Winner is the first requesting channel in the current order
	always_comb begin
		next_grant = '0;
		if (running) begin // RL9 RL11
			for (int i = 3; i >= 0; i--) begin
				if (req_i[order[i]]) begin
					next_grant = '0;
					next_grant[order[i]] = 1'b1; // RL1 RL2 RL3 RL4
				end
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			grant_o    <= '0;
			run_o      <= 1'b0;
			irq_o      <= 1'b0;
			ipl_ch01_o <= 4'h0;
			ipl_ch23_o <= 4'h0;
		end else begin
			grant_o    <= next_grant;
			run_o      <= running; // RL11
			irq_o      <= |(irq_stat & irq_mask);
			ipl_ch01_o <= interrupt_priority_bank_c[`DGOC_IPL01_MSB:`DGOC_IPL01_LSB]; // RL10
			ipl_ch23_o <= interrupt_priority_bank_c[`DGOC_IPL23_MSB:`DGOC_IPL23_LSB]; // RL10
		end
	end

	// Read data, valid only in the cycle after the read strobe
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= '0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				`DGOC_OFF_OPCTL: rdata_o <= opctl_word;
				`DGOC_OFF_INTERRUPT_PRIORITY_BANK_C:  rdata_o <= interrupt_priority_bank_c;
				`DGOC_OFF_STAT:  rdata_o <= {14'h0000, irq_stat};
				`DGOC_OFF_MASK:  rdata_o <= {14'h0000, irq_mask};
				default:         rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end
endmodule : dgoc_top

// ==== dv/dgoc_chan_model.sv ====
// Channel-side model: holds requests and answers each grant with a done pulse.
// Assumes grant_i comes from the block and follows requests by one cycle.
module dgoc_chan_model (
	input  wire logic       clock_i,
	input  wire logic       load_i,
	input  wire logic [3:0] want_i,
	input  wire logic [3:0] grant_i,
	output logic      [3:0] req_o,
	output logic      [3:0] done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pend;
	// Done after a grant, request dropped one cycle later
	always_ff @(posedge clock_i) begin
		done_o <= 4'h0;
		pend <= 1'b0;
		if (load_i) begin
			req_o <= want_i;
		end else if (pend) begin
			req_o <= req_o & ~grant_i;
		end else if ((grant_i & req_o) != 4'h0) begin
			done_o <= grant_i;
			pend <= 1'b1;
		end
	end
endmodule : dgoc_chan_model

// ==== dv/dgoc_top_properties.sv ====
// Assertions on the ports of the operation control block.
// Assumes a bind onto dgoc_top; one clock, reset active low.
module dgoc_top_properties (
	input wire logic        clock_i,
	input wire logic        reset_n_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic [3:0]  req_i,
	input wire logic        addr_err_i,
	input wire logic        nmi_i,
	input wire logic [3:0]  grant_o,
	input wire logic        run_o,
	input wire logic [3:0]  ipl_ch01_o,
	input wire logic [3:0]  ipl_ch23_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	a_grant_onehot: assert property ($onehot0(grant_o))
		else $error("grant not one-hot");
	a_grant_from_req: assert property ((grant_o != 4'h0) |-> ((grant_o & $past(req_i)) == grant_o))
		else $error("grant without request");
	a_ae_stops_run: assert property (addr_err_i |-> ##2 !run_o)
		else $error("run stays after address error");
	a_nmi_stops_run: assert property (nmi_i |-> ##2 !run_o [*2])
		else $error("run stays after nmi");
	a_err_no_grant: assert property (addr_err_i |-> ##3 (grant_o == 4'h0))
		else $error("grant while suspended");
	a_run_needs_write: assert property ($rose(run_o) |-> ($past(wr_i) || $past(wr_i, 2)))
		else $error("run rose without write");
	a_ipl_hold: assert property ((!$past(wr_i) && !$past(wr_i, 2)) |->
		($stable(ipl_ch01_o) && $stable(ipl_ch23_o)))
		else $error("level field changed without write");
	a_rdata_idle: assert property (!$past(rd_i) |-> (rdata_o == 16'h0000))
		else $error("read data outside read cycle");
endmodule : dgoc_top_properties

bind dgoc_top dgoc_top_properties u_props (.clock_i(clock_i), .reset_n_i(reset_n_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .req_i(req_i), .addr_err_i(addr_err_i), .nmi_i(nmi_i), .grant_o(grant_o),
	.run_o(run_o), .ipl_ch01_o(ipl_ch01_o), .ipl_ch23_o(ipl_ch23_o));

// ==== dv/dgoc_top_tb.sv ====
// Testbench for the operation control block: registers, flags, irq, arbitration.
// Assumes the channel model answers every grant; 10 MHz clock.
module dgoc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, wr, rd, ae, nmi, load, run, irq;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, v;
	logic [3:0]  want, req, done, grant, ipl01, ipl23;
	int          fails, cmp_count;
	dgoc_top dut (.clock_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .req_i(req), .done_i(done), .addr_err_i(ae), .nmi_i(nmi), .grant_o(grant),
		.run_o(run), .ipl_ch01_o(ipl01), .ipl_ch23_o(ipl23), .irq_o(irq));
	dgoc_chan_model u_chan (.clock_i(clk), .load_i(load), .want_i(want), .grant_i(grant), .req_o(req),
		.done_o(done));
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(logic [7:0] a, logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic fire(logic [1:0] e);
		@(posedge clk);
		{nmi, ae} <= e;
		@(posedge clk);
		{nmi, ae} <= 2'b00;
	endtask : fire
	task automatic load_req(logic [3:0] w);
		@(posedge clk);
		load <= 1'b1;
		want <= w;
		@(posedge clk);
		load <= 1'b0;
	endtask : load_req
	task automatic t_reset;
		rd_reg(8'h00);
		chk("ctl", 16'h0000, v);
		rd_reg(8'h04);
		chk("bank", 16'h0000, v);
		rd_reg(8'h10);
		chk("unmapped", 16'h0000, v);
		load_req(4'h1);
		repeat (3) @(posedge clk);
		#1 chk("grant", 16'h0000, {12'h0, grant});
		$display("test reset done");
	endtask : t_reset
	task automatic t_flags;
		wr_reg(8'h00, 16'h0001);
		fire(2'b01);
		repeat (2) @(posedge clk);
		#1 chk("run", 16'h0000, {15'h0, run});
		rd_reg(8'h00);
		chk("ctl", 16'h0005, v);
		wr_reg(8'h00, 16'h0005);
		rd_reg(8'h00);
		chk("ctl", 16'h0005, v);
		wr_reg(8'h00, 16'h0001);
		rd_reg(8'h00);
		chk("ctl", 16'h0001, v);
		fire(2'b10);
		wr_reg(8'h00, 16'h0001);
		rd_reg(8'h00);
		chk("ctl", 16'h0003, v);
		wr_reg(8'h00, 16'h0001);
		rd_reg(8'h00);
		chk("ctl", 16'h0001, v);
		$display("test flags done");
	endtask : t_flags
	task automatic t_irq;
		wr_reg(8'h0c, 16'h0001);
		rd_reg(8'h0c);
		chk("mask", 16'h0001, v);
		rd_reg(8'h08);
		chk("status", 16'h0003, v);
		fire(2'b10);
		repeat (3) @(posedge clk);
		#1 chk("irq", 16'h0000, {15'h0, irq});
		fire(2'b01);
		repeat (3) @(posedge clk);
		#1 chk("irq", 16'h0001, {15'h0, irq});
		rd_reg(8'h08);
		chk("status", 16'h0003, v);
		repeat (2) @(posedge clk);
		#1 chk("irq", 16'h0000, {15'h0, irq});
		rd_reg(8'h00);
		chk("ctl", 16'h0007, v);
		wr_reg(8'h00, 16'h0001);
		repeat (2) @(posedge clk);
		#1 chk("run", 16'h0001, {15'h0, run});
		$display("test irq done");
	endtask : t_irq
	task automatic t_ipl;
		wr_reg(8'h04, 16'ha5c3);
		repeat (2) @(posedge clk);
		#1 chk("ipl01", 16'h000a, {12'h0, ipl01});
		chk("ipl23", 16'h0005, {12'h0, ipl23});
		rd_reg(8'h04);
		chk("bank", 16'ha5c3, v);
		$display("test ipl done");
	endtask : t_ipl
	task automatic t_order;
		logic [7:0] exp_seq [4] = '{8'h6c, 8'h2d, 8'h6c, 8'h1b};
		logic [7:0] seq;
		logic [3:0] last;
		int         n;
		for (int m = 0; m < 4; m++) begin
			wr_reg(8'h00, {6'h0, m[1:0], 8'h01});
			load_req(4'hf);
			n = 0;
			last = 4'h0;
			seq = 8'h00;
			repeat (60) begin
				@(posedge clk);
				#1;
				if (grant !== 4'h0 && grant !== last && n < 4) begin
					seq[2*n +: 2] = {grant[3] | grant[2], grant[3] | grant[1]};
					n++;
				end
				last = grant;
			end
			chk("order", {8'h0, exp_seq[m]}, {8'h0, seq});
		end
		$display("test order done");
	endtask : t_order
	task automatic t_midreset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("ipl01", 16'h0000, {12'h0, ipl01});
		chk("run", 16'h0000, {15'h0, run});
		rd_reg(8'h00);
		chk("ctl", 16'h0000, v);
		$display("test midreset done");
	endtask : t_midreset
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	// Clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Main sequence
	initial begin
		fails = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		{wr, rd, ae, nmi} = 4'h0;
		load = 1'b1;
		want = 4'h0;
		addr = 8'h00;
		wdata = 16'h0000;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_flags;
		t_irq;
		t_ipl;
		t_order;
		t_midreset;
		report_and_stop;
	end
	// Watchdog, about 10000 cycles
	initial begin
		#1000000;
		fails++;
		report_and_stop;
	end
endmodule : dgoc_top_tb
